// file: src/nlc_pkg.sv
// Constants, field layouts and carrier types for the luma noise coring stage.
// Assumes one system clock; pixels arrive with a one-cycle valid strobe.
`default_nettype none

package nlc_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_EDGE_CTRL = 8'h82;
  localparam logic [7:0] REG_CORING_GAIN_PAIR = 8'ha3;
  localparam logic [7:0] REG_THRESHOLD_AND_BLOCK_SHAPE = 8'ha4;
  localparam logic [7:0] REG_FILTER_MODE_AND_OFFSET = 8'ha5;

  localparam logic [7:0] RESET_EDGE_CTRL = 8'h00;
  localparam logic [7:0] RESET_CORING_GAIN_PAIR = 8'h00;
  localparam logic [7:0] RESET_THRESHOLD_AND_BLOCK_SHAPE = 8'h00;
  localparam logic [7:0] RESET_FILTER_MODE_AND_OFFSET = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int EDGE_EN_BIT = 7;
  localparam int GAIN_BORDER_LSB = 0;
  localparam int GAIN_DATA_LSB = 4;
  localparam int THRESH_LSB = 0;
  localparam int BORDER_AREA_BIT = 6;
  localparam int BLOCK_SIZE_BIT = 7;
  localparam int FILTER_SEL_LSB = 0;
  localparam int MODE_BIT = 4;
  localparam int OFFSET_LSB = 4;

  // ----------------------------------------------------------------------
  // Arithmetic constants
  // ----------------------------------------------------------------------
  localparam logic [3:0] GAIN_MAX_CODE = 4'h8;
  localparam int SUB_SHIFT = 3;
  localparam int SHARP_SHIFT = 4;
  localparam logic [3:0] EDGE_W_1_8 = 4'h1;
  localparam logic [3:0] EDGE_W_1_2 = 4'h4;
  localparam logic [3:0] EDGE_W_7_8 = 4'h7;
  localparam logic [3:0] EDGE_W_ONE = 4'h8;
  localparam int EDGE_SHIFT = 3;
  localparam logic [3:0] BLOCK_MASK_8 = 4'h7;
  localparam logic [3:0] BLOCK_MASK_16 = 4'hf;
  localparam int TAPS = 9;
  localparam int CENTER = 4;

  typedef enum logic {
    MODE_SUBTRACT = 1'b0,
    MODE_SHARPEN = 1'b1
  } nlc_mode_t;

  typedef struct packed {
    logic active;
    logic [7:0] luma;
    logic [7:0] chroma;
  } nlc_pix_t;

endpackage

`default_nettype wire

// file: src/nlc_filter.sv
// Pixel delay line and selectable high-pass filter for the coring stage.
// Assumes shifts happen only on the pixel valid strobe.
`default_nettype none

module nlc_filter
  import nlc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Incoming pixel
  input wire logic valid_i,
  input wire nlc_pix_t pix_i,
  input wire logic [2:0] sel_i,
  // Centre pixel with filter output
  output logic valid_o,
  output nlc_pix_t center_o,
  output logic signed [9:0] hp_o,
  output logic [2:0] ahead_o
);

  nlc_pix_t taps [TAPS];
  logic [2:0] span;
  logic [8:0] pair_sum;
  logic signed [9:0] hp;

  // ----------------------------------------------------------------------
  // Delay line
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < TAPS; i++) begin
        taps[i] <= '0;
      end
    end else if (valid_i) begin
      taps[0] <= pix_i;
      for (int i = 1; i < TAPS; i++) begin
        taps[i] <= taps[i-1];
      end
    end
  end

  // Filter: centre minus the mean of two neighbours at a chosen span.
  // The upper select bit halves the response without changing the passband.
  always_comb begin
    span = {1'b0, sel_i[1:0]} + 3'h1;
    pair_sum = {1'b0, taps[CENTER - int'(span)].luma}
             + {1'b0, taps[CENTER + int'(span)].luma};
    hp = $signed({2'b00, taps[CENTER].luma})
       - $signed({2'b00, pair_sum[8:1]});
    if (sel_i[2]) begin
      hp = hp >>> 1;
    end
  end

  // ----------------------------------------------------------------------
  // Output register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
      center_o <= '0;
      hp_o <= '0;
      ahead_o <= '0;
    end else begin
      valid_o <= valid_i;
      if (valid_i) begin
        center_o <= taps[CENTER];
        hp_o <= hp;
        // Look-ahead flags, with the nearest following pixel in the top bit.
        ahead_o <= {taps[3].active, taps[2].active, taps[1].active};
      end
    end
  end

endmodule

`default_nettype wire

// file: src/nlc_core.sv
// Luma noise coring, sharpening and active-video edge softening stage.
// Assumes the upstream source gives one valid strobe per pixel and a level
// that marks active video; the register port is written by a controller.
`default_nettype none

module nlc_core
  import nlc_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  // Pixel input
  input wire logic PIX_VALID_I,
  input wire logic ACTIVE_I,
  input wire logic [7:0] LUMA_I,
  input wire logic [7:0] CHROMA_I,
  // Register port
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  // Pixel output
  output logic PIX_VALID_O,
  output logic ACTIVE_O,
  output logic [7:0] LUMA_O,
  output logic [7:0] CHROMA_O
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  function automatic logic [3:0] clamp_gain(input logic [3:0] code);
    clamp_gain = (code > GAIN_MAX_CODE) ? GAIN_MAX_CODE : code;
  endfunction

  function automatic logic [7:0] sat8(input logic signed [11:0] v);
    if (v < 0) begin
      sat8 = 8'h00;
    end else if (v > 12'sd255) begin
      sat8 = 8'hff;
    end else begin
      sat8 = v[7:0];
    end
  endfunction

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic edge_en;
  logic [7:0] coring_gain_pair;
  logic [7:0] threshold_and_block_shape;
  logic [7:0] filter_mode_and_offset;

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      edge_en <= RESET_EDGE_CTRL[EDGE_EN_BIT];
      coring_gain_pair <= RESET_CORING_GAIN_PAIR;
      threshold_and_block_shape <= RESET_THRESHOLD_AND_BLOCK_SHAPE;
      filter_mode_and_offset <= RESET_FILTER_MODE_AND_OFFSET;
    end else if (REG_WR_I) begin
      case (REG_ADDR_I)
        REG_EDGE_CTRL: begin
          edge_en <= REG_WDATA_I[EDGE_EN_BIT];
        end
        REG_CORING_GAIN_PAIR: begin
          coring_gain_pair <= REG_WDATA_I;
        end
        REG_THRESHOLD_AND_BLOCK_SHAPE: begin
          threshold_and_block_shape <= REG_WDATA_I;
        end
        REG_FILTER_MODE_AND_OFFSET: begin
          filter_mode_and_offset <= REG_WDATA_I;
        end
        default: begin
        end
      endcase
    end
  end

  // Reads return the stored value one cycle later; other addresses read 0.
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (REG_RD_I) begin
      case (REG_ADDR_I)
        REG_EDGE_CTRL: begin
          REG_RDATA_O <= {edge_en, 7'h00};
        end
        REG_CORING_GAIN_PAIR: begin
          REG_RDATA_O <= coring_gain_pair;
        end
        REG_THRESHOLD_AND_BLOCK_SHAPE: begin
          REG_RDATA_O <= threshold_and_block_shape;
        end
        REG_FILTER_MODE_AND_OFFSET: begin
          REG_RDATA_O <= filter_mode_and_offset;
        end
        default: begin
          REG_RDATA_O <= 8'h00;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------------
  logic [3:0] gain_border;
  logic [3:0] gain_data;
  logic [5:0] threshold;
  logic border_wide;
  logic block_large;
  logic [2:0] filter_sel;
  nlc_mode_t mode;
  logic [3:0] block_offset;

  // The mode bit sits inside the offset field, so offset bit 0 and the
  // mode share one storage bit; software must pick a consistent pair.
  always_comb begin
    gain_border = coring_gain_pair[GAIN_BORDER_LSB +: 4];
    gain_data = coring_gain_pair[GAIN_DATA_LSB +: 4];
    threshold = threshold_and_block_shape[THRESH_LSB +: 6];
    border_wide = threshold_and_block_shape[BORDER_AREA_BIT];
    block_large = threshold_and_block_shape[BLOCK_SIZE_BIT];
    filter_sel = filter_mode_and_offset[FILTER_SEL_LSB +: 3];
    mode = nlc_mode_t'(filter_mode_and_offset[MODE_BIT]);
    block_offset = filter_mode_and_offset[OFFSET_LSB +: 4];
  end

  // ----------------------------------------------------------------------
  // Filter
  // ----------------------------------------------------------------------
  nlc_pix_t pix_in;
  logic ctr_valid;
  nlc_pix_t ctr;
  logic signed [9:0] hp;
  logic [2:0] ahead;

  assign pix_in = '{active: ACTIVE_I, luma: LUMA_I, chroma: CHROMA_I};

  nlc_filter u_filter (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .valid_i(PIX_VALID_I),
    .pix_i(pix_in),
    .sel_i(filter_sel),
    .valid_o(ctr_valid),
    .center_o(ctr),
    .hp_o(hp),
    .ahead_o(ahead)
  );

  // ----------------------------------------------------------------------
  // Position in line and in block
  // ----------------------------------------------------------------------
  // Lines longer than 4096 pixels hold the counter at its top, so the tail
  // weights still come from the look-ahead flags and never wrap around.
  logic [11:0] line_pos;

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      line_pos <= 12'h000;
    end else if (ctr_valid) begin
      if (ctr.active) begin
        if (line_pos != 12'hfff) begin
          line_pos <= line_pos + 12'h001;
        end
      end else begin
        line_pos <= 12'h000;
      end
    end
  end

  logic [3:0] block_mask;
  logic [3:0] block_pos;
  logic in_border;

  always_comb begin
    block_mask = block_large ? BLOCK_MASK_16 : BLOCK_MASK_8;
    block_pos = (line_pos[3:0] + block_offset) & block_mask;
    if (border_wide) begin
      in_border = (block_pos == 4'h0) || (block_pos == 4'h1)
               || (block_pos == block_mask)
               || (block_pos == block_mask - 4'h1);
    end else begin
      in_border = (block_pos == 4'h0) || (block_pos == block_mask);
    end
  end

  // ----------------------------------------------------------------------
  // Coring
  // ----------------------------------------------------------------------
  logic [9:0] mag;
  logic [3:0] gain;
  logic signed [14:0] prod;
  logic signed [11:0] adj;
  logic signed [11:0] cored;

  // A magnitude equal to the threshold leaves the sample alone in both
  // modes, so one threshold never both adds and subtracts.

  always_comb begin
    mag = hp[9] ? 10'(-hp) : 10'(hp);
    gain = clamp_gain(in_border ? gain_border : gain_data);
    prod = 15'(hp) * $signed({1'b0, gain});
    adj = 12'sd0;
    cored = $signed({4'h0, ctr.luma});
    case (mode)
      MODE_SUBTRACT: begin
        if (mag < {4'h0, threshold}) begin
          adj = 12'(prod >>> SUB_SHIFT);
          cored = cored - adj;
        end
      end
      MODE_SHARPEN: begin
        if (mag > {4'h0, threshold}) begin
          adj = 12'(prod >>> SHARP_SHIFT);
          cored = cored + adj;
        end
      end
      default: begin
        cored = $signed({4'h0, ctr.luma});
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Edge softening
  // ----------------------------------------------------------------------
  // The look-ahead flags carry the next pixel in bit 2, the third in bit 0.
  logic [3:0] edge_w;
  logic [7:0] cored8;
  logic [11:0] scaled;

  always_comb begin
    edge_w = EDGE_W_ONE;
    if (edge_en) begin
      if (line_pos == 12'h000) begin
        edge_w = EDGE_W_1_8;
      end else if (line_pos == 12'h001) begin
        edge_w = EDGE_W_1_2;
      end else if (line_pos == 12'h002) begin
        edge_w = EDGE_W_7_8;
      end else if (!ahead[2]) begin
        edge_w = EDGE_W_1_8;
      end else if (!ahead[1]) begin
        edge_w = EDGE_W_1_2;
      end else if (!ahead[0]) begin
        edge_w = EDGE_W_7_8;
      end
    end
    cored8 = sat8(cored);
    scaled = (12'(cored8) * 12'(edge_w)) >> EDGE_SHIFT;
  end

  // ----------------------------------------------------------------------
  // Output register
  // ----------------------------------------------------------------------
  // Blanking pixels bypass coring so sync and blanking levels stay exact.
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      PIX_VALID_O <= 1'b0;
      ACTIVE_O <= 1'b0;
      LUMA_O <= 8'h00;
      CHROMA_O <= 8'h00;
    end else begin
      PIX_VALID_O <= ctr_valid;
      if (ctr_valid) begin
        ACTIVE_O <= ctr.active;
        CHROMA_O <= ctr.chroma;
        if (ctr.active) begin
          LUMA_O <= scaled[7:0];
        end else begin
          LUMA_O <= ctr.luma;
        end
      end
    end
  end

endmodule

`default_nettype wire

// file: test/nlc_source.sv
// Upstream video source model feeding pixels to the coring stage.
// Assumes the bench calls send once per pixel from a single process.
`default_nettype none

module nlc_source (
  // Clock
  input wire logic clk_i,
  // Pixel stream
  output logic valid_o,
  output logic active_o,
  output logic [7:0] luma_o,
  output logic [7:0] chroma_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------
  // Driver
  // ----------------
  initial begin
    valid_o = 1'b0;
    active_o = 1'b0;
    luma_o = 8'h00;
    chroma_o = 8'h00;
  end
  // Lines are inverted off the strobe so a stage that samples there
  // sees wrong data instead of a lucky repeat.
  task automatic send(input logic a, input logic [7:0] y,
    input logic [7:0] c, input int gap);
    @(negedge clk_i);
    valid_o = 1'b1;
    active_o = a;
    luma_o = y;
    chroma_o = c;
    if (gap > 0) begin
      @(negedge clk_i);
      valid_o = 1'b0;
      active_o = ~a;
      luma_o = ~y;
      chroma_o = ~c;
      repeat (gap - 1) @(negedge clk_i);
    end
  endtask
endmodule

`default_nettype wire

// file: test/nlc_core_checker.sv
// Port assertions for the luma coring stage.
// Assumes one clock domain and a synchronous active-high reset.
`default_nettype none

module nlc_core_checker
  import nlc_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  // Pixel stream
  input wire logic PIX_VALID_I,
  input wire logic ACTIVE_I,
  input wire logic [7:0] LUMA_I,
  input wire logic [7:0] CHROMA_I,
  input wire logic PIX_VALID_O,
  input wire logic ACTIVE_O,
  input wire logic [7:0] LUMA_O,
  input wire logic [7:0] CHROMA_O,
  // Register port
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_RDATA_O
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------
  // Properties
  // ----------------
  default clocking dc @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RST_I);
  logic cfg_addr;
  assign cfg_addr = REG_ADDR_I inside {REG_CORING_GAIN_PAIR,
    REG_THRESHOLD_AND_BLOCK_SHAPE, REG_FILTER_MODE_AND_OFFSET};
  // Only an unbroken run of strobes fixes which input an output carries.
  sequence run_of_six;
    PIX_VALID_I [*6];
  endsequence
  sequence wr_then_rd;
    REG_WR_I && cfg_addr ##1 REG_RD_I && $stable(REG_ADDR_I);
  endsequence
  valid_latency_a: assert property (PIX_VALID_I |-> ##2 PIX_VALID_O)
    else $error("Output strobe missing after input strobe.");
  no_spurious_a: assert property (!PIX_VALID_I |-> ##2 !PIX_VALID_O)
    else $error("Output strobe without input strobe.");
  hold_between_a: assert property (!PIX_VALID_O |-> $stable(LUMA_O) &&
    $stable(CHROMA_O) && $stable(ACTIVE_O))
    else $error("Output pixel changed between strobes.");
  chroma_through_a: assert property (run_of_six |-> ##2
    CHROMA_O == $past(CHROMA_I, 7))
    else $error("Chroma altered on its way through.");
  blank_through_a: assert property (run_of_six |-> ##2
    ACTIVE_O == $past(ACTIVE_I, 7) && (ACTIVE_O || LUMA_O == $past(LUMA_I, 7)))
    else $error("Blank pixel altered on its way through.");
  reg_readback_a: assert property (wr_then_rd |=>
    REG_RDATA_O == $past(REG_WDATA_I, 2))
    else $error("Register read does not return the written value.");
  unmapped_zero_a: assert property (REG_RD_I && !cfg_addr &&
    REG_ADDR_I != REG_EDGE_CTRL |=> REG_RDATA_O == 8'h00)
    else $error("Unmapped read returned nonzero data.");
  edge_bits_a: assert property (REG_RD_I &&
    REG_ADDR_I == REG_EDGE_CTRL |=> REG_RDATA_O[6:0] == 7'h00)
    else $error("Edge control read shows unused bits.");
  rdata_hold_a: assert property (!REG_RD_I |=> $stable(REG_RDATA_O))
    else $error("Read data changed without a read.");
endmodule

bind nlc_core nlc_core_checker chk (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I),
  .PIX_VALID_I(PIX_VALID_I), .ACTIVE_I(ACTIVE_I), .LUMA_I(LUMA_I),
  .CHROMA_I(CHROMA_I), .PIX_VALID_O(PIX_VALID_O), .ACTIVE_O(ACTIVE_O),
  .LUMA_O(LUMA_O), .CHROMA_O(CHROMA_O), .REG_ADDR_I(REG_ADDR_I),
  .REG_WR_I(REG_WR_I), .REG_WDATA_I(REG_WDATA_I), .REG_RD_I(REG_RD_I),
  .REG_RDATA_O(REG_RDATA_O));

`default_nettype wire

// file: test/nlc_core_tb.sv
// Self-checking bench for the luma coring stage with a reference model.
// Assumes nlc_pkg, nlc_core, nlc_source and the checker are compiled.
`default_nettype none

module nlc_core_tb
  import nlc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wd = 8'h00;
  logic [7:0] r82 = 8'h00, ra3 = 8'h00, ra4 = 8'h00, ra5 = 8'h00;
  logic pv, pa, ov, oa;
  logic [7:0] py, pc, rdata, oy, oc;
  logic [16:0] expq[$];
  int ya[2048], aa[2048], ca[2048];
  int n = 0, mpos = 0, n_mismatch = 0, checks = 0, cyc = 0;
  int seed = 32'hf0f8;

  always #5 clk = ~clk;

  nlc_source src (.clk_i(clk), .valid_o(pv), .active_o(pa), .luma_o(py),
    .chroma_o(pc));
  nlc_core uut (.CLK_SYS_I(clk), .RST_I(rst), .PIX_VALID_I(pv),
    .ACTIVE_I(pa), .LUMA_I(py), .CHROMA_I(pc), .REG_ADDR_I(addr),
    .REG_WR_I(we), .REG_WDATA_I(wd), .REG_RD_I(re), .REG_RDATA_O(rdata),
    .PIX_VALID_O(ov), .ACTIVE_O(oa), .LUMA_O(oy), .CHROMA_O(oc));

  // ----------------
  // Model and tasks
  // ----------------
  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] rexp(logic [7:0] a);
    case (a)
      REG_EDGE_CTRL: return {r82[7], 7'h00};
      REG_CORING_GAIN_PAIR: return ra3;
      REG_THRESHOLD_AND_BLOCK_SHAPE: return ra4;
      REG_FILTER_MODE_AND_OFFSET: return ra5;
      default: return 8'h00;
    endcase
  endfunction

  // Pixel c leaves after strobe c+5; taps before it are cleared to zero.
  function automatic logic [16:0] model(int c);
    int d, hp, m, mk, p, g, y, w;
    if (c < 0) return 17'h00000;
    d = ra5[1:0] + 1;
    hp = ya[c] - ((((c < d) ? 0 : ya[c - d]) + ya[c + d]) >> 1);
    if (ra5[2]) hp = hp >>> 1;
    m = (hp < 0) ? -hp : hp;
    mk = ra4[7] ? 15 : 7;
    p = ((mpos & 15) + ra5[7:4]) & mk;
    g = (p == 0 || p == mk || (ra4[6] && (p == 1 || p == mk - 1))) ?
      ra3[3:0] : ra3[7:4];
    g = (g > 8) ? 8 : g;
    y = ya[c];
    if (!ra5[4] && m < ra4[5:0]) y -= (hp * g) >>> 3;
    if (ra5[4] && m > ra4[5:0]) y += (hp * g) >>> 4;
    y = (y < 0) ? 0 : (y > 255) ? 255 : y;
    w = 8;
    if (r82[7]) begin
      if (mpos < 3) w = (mpos == 0) ? 1 : (mpos == 1) ? 4 : 7;
      else if (!aa[c + 1]) w = 1;
      else if (!aa[c + 2]) w = 4;
      else if (!aa[c + 3]) w = 7;
    end
    mpos = aa[c] ? mpos + 1 : 0;
    if (!aa[c]) return {1'b0, ya[c][7:0], ca[c][7:0]};
    return {1'b1, 8'((y * w) >> 3), ca[c][7:0]};
  endfunction

  task automatic acc(input logic [7:0] a, input logic [7:0] d,
    input logic w);
    @(negedge clk);
    addr = a;
    wd = d;
    we = w;
    @(negedge clk);
    we = 1'b0;
    re = 1'b1;
    @(negedge clk);
    re = 1'b0;
    if (w && a == REG_EDGE_CTRL) r82 = d;
    if (w && a == REG_CORING_GAIN_PAIR) ra3 = d;
    if (w && a == REG_THRESHOLD_AND_BLOCK_SHAPE) ra4 = d;
    if (w && a == REG_FILTER_MODE_AND_OFFSET) ra5 = d;
    check({9'h000, rdata}, {9'h000, rexp(a)});
  endtask

  task automatic pix(input logic a, input int gap);
    logic [7:0] y, c;
    y = ($random(seed) & 3) ? 8'h60 + 8'($random(seed) & 15) :
      8'($random(seed));
    c = 8'($random(seed));
    ya[n] = y;
    aa[n] = a;
    ca[n] = c;
    expq.push_back(model(n - 5));
    n++;
    src.send(a, y, c, gap);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(negedge clk) begin
    cyc++;
    if (!rst && ov === 1'b1) begin
      check({oa, oy, oc}, expq.pop_front());
    end
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  // ----------------
  // Sequence
  // ----------------
  initial begin
    int t, len;
    logic [7:0] adr[5];
    adr = '{REG_EDGE_CTRL, REG_CORING_GAIN_PAIR,
      REG_THRESHOLD_AND_BLOCK_SHAPE, REG_FILTER_MODE_AND_OFFSET, 8'h10};
    repeat (3) @(negedge clk);
    rst = 1'b0;
    foreach (adr[i]) acc(adr[i], 8'h00, 1'b0);
    $display("reset value test done");
    for (t = 0; t < 16; t++) begin
      acc(REG_EDGE_CTRL, {t[1], 7'($random(seed))}, 1'b1);
      acc(REG_CORING_GAIN_PAIR, 8'($random(seed)), 1'b1);
      acc(REG_THRESHOLD_AND_BLOCK_SHAPE, 8'($random(seed)), 1'b1);
      acc(REG_FILTER_MODE_AND_OFFSET, {3'($random(seed)), t[3],
        1'($random(seed)), t[2:0]}, 1'b1);
      acc(8'h10, 8'hff, 1'b1);
      len = (t < 3) ? t + 1 : 6 + ($random(seed) & 31);
      repeat (2) pix(1'b0, t[0] ? 0 : 1);
      repeat (len) pix(1'b1, t[0] ? 0 : ($random(seed) & 1));
      repeat (5) pix(1'b0, 1);
      repeat (4) @(negedge clk);
      $display("line test %0d done", t);
    end
    repeat (8) @(negedge clk);
    check(17'(expq.size()), 17'h00000);
    wrap_up();
  end
endmodule

`default_nettype wire
